// file: verilog/sspc_map.svh
// Constants for the sleep and standby power sequencer.
`ifndef SSPC_MAP_SVH
`define SSPC_MAP_SVH
`define SSPC_STANDBY_SELECT_BIT_RESET 1'b0
`define SSPC_STS_RESET 3'h0
`define SSPC_STS_8K 3'h0
`define SSPC_STS_16K 3'h1
`define SSPC_STS_32K 3'h2
`define SSPC_STS_64K 3'h3
`define SSPC_STS_128K 3'h4
`define SSPC_STS_1K 3'h5
`define SSPC_WAIT_8K 18'h0_2000
`define SSPC_WAIT_16K 18'h0_4000
`define SSPC_WAIT_32K 18'h0_8000
`define SSPC_WAIT_64K 18'h1_0000
`define SSPC_WAIT_128K 18'h2_0000
`define SSPC_WAIT_1K 18'h0_0400
`define SSPC_RFSH_CLR_MSB 7
`define SSPC_RFSH_CLR_LSB 6
`define SSPC_IRQ_PINS 3
`endif

// file: verilog/sspc_pkg.sv
// Types shared by the sleep and standby power sequencer files.
package sspc_pkg;
  typedef enum logic [5:0] {
    SSPC_RUN = 6'b00_0001,
    SSPC_SLEEP = 6'b00_0010,
    SSPC_SWSTBY = 6'b00_0100,
    SSPC_SETTLE = 6'b00_1000,
    SSPC_RSTOSC = 6'b01_0000,
    SSPC_HWSTBY = 6'b10_0000
  } sspc_state_t;

  // Wake request bundle from the interrupt side.
  typedef struct packed {
    logic nmi;
    logic [2:0] irqPend;
    logic [2:0] irqEnable;
    logic irqCpuMasked;
    logic periphReq;
    logic periphEnabled;
    logic periphCpuMasked;
  } sspc_wake_t;

  // Clock and module control bundle toward the chip.
  typedef struct packed {
    logic cpuRun;
    logic oscRun;
    logic clockOn;
    logic periphRun;
    logic periphReset;
    logic refreshInit;
  } sspc_ctl_t;
endpackage : sspc_pkg

// file: verilog/sspc_wake_filter.sv
// Qualifies interrupt requests into sleep and standby wake events.
`timescale 1ns/1ps
module sspc_wake_filter (
  input wire sspc_pkg::sspc_wake_t wake,
  output logic sleepWake,
  output logic standbyWake
);
  // Sleep wakes on NMI, enabled unmasked pins or an enabled unmasked peripheral.
  assign sleepWake = wake.nmi
    | ((|(wake.irqPend & wake.irqEnable)) & ~wake.irqCpuMasked)
    | (wake.periphReq & wake.periphEnabled & ~wake.periphCpuMasked);
  // Standby wakes only on NMI or enabled unmasked external pins.
  assign standbyWake = wake.nmi
    | ((|(wake.irqPend & wake.irqEnable)) & ~wake.irqCpuMasked);
endmodule : sspc_wake_filter

// file: verilog/sspc_settle_timer.sv
// Settling wait counter loaded from the settle-time select code.
`timescale 1ns/1ps
`include "sspc_map.svh"
module sspc_settle_timer (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic load,
  input wire logic tick,
  input wire logic [2:0] settleTimeSelect,
  output logic done
);
  logic [17:0] count_q;
  logic [17:0] loadVal;

  // Decode the code into a wait in divided clock states.
  always_comb begin
    unique case (settleTimeSelect)
      `SSPC_STS_8K: loadVal = `SSPC_WAIT_8K;
      `SSPC_STS_16K: loadVal = `SSPC_WAIT_16K;
      `SSPC_STS_32K: loadVal = `SSPC_WAIT_32K;
      `SSPC_STS_64K: loadVal = `SSPC_WAIT_64K;
      `SSPC_STS_128K: loadVal = `SSPC_WAIT_128K;
      `SSPC_STS_1K: loadVal = `SSPC_WAIT_1K;
      default: loadVal = `SSPC_WAIT_128K; // Illegal codes take the longest wait.
    endcase
  end

  // Count down one per divided state after load.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 18'h0_0000;
    end else if (clockEnable) begin
      if (load) begin
        count_q <= loadVal;
      end else if (tick && count_q != 18'h0_0000) begin
        count_q <= count_q - 18'h0_0001;
      end
    end
  end

  assign done = (count_q == 18'h0_0001) && tick && !load;
endmodule : sspc_settle_timer

// file: verilog/sspc_power_seq.sv
// Sleep and software standby power sequencer top level.
// What this block does
// - Sleep instruction with select clear enters sleep.
// - CPU halts after sleep, registers kept.
// - Peripherals run in sleep unless module-stopped.
// - Accepted interrupt ends sleep into exception.
// - Peripheral-disabled interrupt does not wake sleep.
// - CPU-masked non-NMI interrupt does not wake.
// - Low reset pin ends sleep into reset.
// - Low standby pin in sleep enters hardware standby.
// - Select set makes sleep enter software standby.
// - Standby stops all clocks, resets peripherals.
// - Standby keeps CPU, RAM, port, refresh settings.
// - Standby entry clears refresh counter, bits 7-6.
// - Standby exits only on NMI, IRQ0-2, pins.
// - Interrupt wake: oscillator, settle wait, then clocks.
// - Disabled or masked IRQ pins keep standby.
// - Reset low restarts clocks; release starts reset.
// - Low standby pin in standby enters hardware standby.
// - Settle code selects 8K..128K or 1K states.
// - Select bit stays set after interrupt wake.
`timescale 1ns/1ps
`include "sspc_map.svh"
module sspc_power_seq (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic sleepExec,
  input wire logic selWrite,
  input wire logic selWriteData,
  input wire logic [2:0] settleWriteData,
  input wire logic divTick,
  input wire logic [6:0] moduleStop,
  input wire sspc_pkg::sspc_wake_t wake,
  input wire logic chip_rst_n_pin,
  input wire logic hw_standby_n_pin,
  output logic standby_select_bit,
  output logic [2:0] settle_time_select,
  output sspc_pkg::sspc_ctl_t ctl,
  output logic [6:0] moduleRun,
  output logic [1:0] refreshStatusClear,
  output logic refreshCountClear,
  output logic interruptStart,
  output logic resetStart,
  output logic hwStandby,
  output logic [5:0] stateOut
);
  sspc_pkg::sspc_state_t state_q;
  sspc_pkg::sspc_state_t state_d;
  logic sleepWake;
  logic standbyWake;
  logic settleDone;
  logic settleLoad;
  logic rstLow;
  logic stbyLow;
  logic [2:0] settleCode_q;
  logic [17:0] settleTicks_q;
  logic [17:0] settleExpect;

  //////////////////////////////////////////////////////////////////////////////
  // Wake qualification and settle timer.

  sspc_wake_filter sspc_wake_filter_inst (
    .wake(wake),
    .sleepWake(sleepWake),
    .standbyWake(standbyWake)
  );

  sspc_settle_timer sspc_settle_timer_inst (
    .clock(clock),
    .reset_n(reset_n),
    .clockEnable(clockEnable),
    .load(settleLoad),
    .tick(divTick),
    .settleTimeSelect(settle_time_select),
    .done(settleDone)
  );

  assign rstLow = !chip_rst_n_pin;
  assign stbyLow = !hw_standby_n_pin;
  // The timer loads as standby sees its qualified wake.
  assign settleLoad = (state_q == sspc_pkg::SSPC_SWSTBY) && standbyWake
    && !rstLow && !stbyLow;

  //////////////////////////////////////////////////////////////////////////////
  // Control register bits written by software.

  // The select bit only changes on a write, so a wake leaves it set.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      standby_select_bit <= `SSPC_STANDBY_SELECT_BIT_RESET;
      settle_time_select <= `SSPC_STS_RESET;
    end else if (clockEnable) begin
      if (selWrite) begin
        standby_select_bit <= selWriteData;
        settle_time_select <= settleWriteData;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode sequencer.

  // Next state; standby pin has priority over reset pin, then wakes.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sspc_pkg::SSPC_RUN: begin
        if (stbyLow) begin
          state_d = sspc_pkg::SSPC_HWSTBY;
        end else if (sleepExec && !standby_select_bit) begin
          state_d = sspc_pkg::SSPC_SLEEP;
        end else if (sleepExec && standby_select_bit) begin
          state_d = sspc_pkg::SSPC_SWSTBY;
        end
      end
      sspc_pkg::SSPC_SLEEP: begin
        if (stbyLow) begin
          state_d = sspc_pkg::SSPC_HWSTBY;
        end else if (rstLow) begin
          state_d = sspc_pkg::SSPC_RSTOSC;
        end else if (sleepWake) begin
          state_d = sspc_pkg::SSPC_RUN;
        end
      end
      sspc_pkg::SSPC_SWSTBY: begin
        if (stbyLow) begin
          state_d = sspc_pkg::SSPC_HWSTBY;
        end else if (rstLow) begin
          state_d = sspc_pkg::SSPC_RSTOSC;
        end else if (standbyWake) begin
          state_d = sspc_pkg::SSPC_SETTLE;
        end
      end
      sspc_pkg::SSPC_SETTLE: begin
        if (stbyLow) begin
          state_d = sspc_pkg::SSPC_HWSTBY;
        end else if (rstLow) begin
          state_d = sspc_pkg::SSPC_RSTOSC;
        end else if (settleDone) begin
          state_d = sspc_pkg::SSPC_RUN;
        end
      end
      sspc_pkg::SSPC_RSTOSC: begin
        if (stbyLow) begin
          state_d = sspc_pkg::SSPC_HWSTBY;
        end else if (!rstLow) begin
          state_d = sspc_pkg::SSPC_RUN;
        end
      end
      sspc_pkg::SSPC_HWSTBY: begin
        if (!stbyLow) begin
          state_d = sspc_pkg::SSPC_RSTOSC;
        end
      end
      default: state_d = sspc_pkg::SSPC_RUN;
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= sspc_pkg::SSPC_RUN;
    end else if (clockEnable) begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward CPU, clocks and modules.

  // Clock, CPU and peripheral controls follow the next state.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= '{cpuRun: 1'b1, oscRun: 1'b1, clockOn: 1'b1, periphRun: 1'b1,
        periphReset: 1'b0, refreshInit: 1'b0};
      moduleRun <= 7'h7f;
      stateOut <= 6'h01;
    end else if (clockEnable) begin
      ctl.cpuRun <= (state_d == sspc_pkg::SSPC_RUN);
      ctl.oscRun <= !(state_d == sspc_pkg::SSPC_SWSTBY || state_d == sspc_pkg::SSPC_HWSTBY);
      ctl.clockOn <= (state_d == sspc_pkg::SSPC_RUN || state_d == sspc_pkg::SSPC_SLEEP
        || state_d == sspc_pkg::SSPC_RSTOSC);
      ctl.periphRun <= (state_d == sspc_pkg::SSPC_RUN || state_d == sspc_pkg::SSPC_SLEEP);
      ctl.periphReset <= (state_d == sspc_pkg::SSPC_SWSTBY
        || state_d == sspc_pkg::SSPC_SETTLE);
      // Register, RAM and port hold is implied: only peripherals are reset.
      ctl.refreshInit <= (state_d == sspc_pkg::SSPC_SWSTBY);
      moduleRun <= (state_d == sspc_pkg::SSPC_RUN || state_d == sspc_pkg::SSPC_SLEEP)
        ? ~moduleStop : 7'h00;
      stateOut <= 6'(state_d);
    end
  end

  // One-cycle strobes on transitions, and the hardware standby level.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refreshStatusClear <= 2'h0;
      refreshCountClear <= 1'b0;
      interruptStart <= 1'b0;
      resetStart <= 1'b0;
      hwStandby <= 1'b0;
    end else if (clockEnable) begin
      refreshCountClear <= (state_d == sspc_pkg::SSPC_SWSTBY)
        && (state_q == sspc_pkg::SSPC_RUN);
      refreshStatusClear <= ((state_d == sspc_pkg::SSPC_SWSTBY)
        && (state_q == sspc_pkg::SSPC_RUN)) ? 2'h3 : 2'h0;
      interruptStart <= (state_d == sspc_pkg::SSPC_RUN)
        && (state_q == sspc_pkg::SSPC_SLEEP || state_q == sspc_pkg::SSPC_SETTLE);
      resetStart <= (state_d == sspc_pkg::SSPC_RUN)
        && (state_q == sspc_pkg::SSPC_RSTOSC);
      hwStandby <= (state_d == sspc_pkg::SSPC_HWSTBY);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  sleep_entry_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_RUN && sleepExec && !stbyLow
      && !standby_select_bit) |=> state_q == sspc_pkg::SSPC_SLEEP)
    else $error("sleep not entered");
  standby_entry_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_RUN && sleepExec && !stbyLow
      && standby_select_bit) |=> state_q == sspc_pkg::SSPC_SWSTBY && !ctl.clockOn)
    else $error("standby not entered");
  cpu_halt_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == sspc_pkg::SSPC_SLEEP && clockEnable && !sleepWake && !rstLow && !stbyLow)
      |=> !ctl.cpuRun && ctl.periphRun)
    else $error("cpu not halted in sleep");
  masked_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == sspc_pkg::SSPC_SWSTBY && !standbyWake && !rstLow && !stbyLow)
      |=> state_q == sspc_pkg::SSPC_SWSTBY)
    else $error("standby left without wake");
  refresh_init_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_RUN && state_d == sspc_pkg::SSPC_SWSTBY)
      |=> refreshCountClear && refreshStatusClear == 2'h3)
    else $error("refresh not initialised");
  sel_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!selWrite) |=> standby_select_bit == $past(standby_select_bit))
    else $error("select bit changed without write");
  hw_standby_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && stbyLow) |=> state_q == sspc_pkg::SSPC_HWSTBY && hwStandby)
    else $error("hardware standby missed");
  reset_exit_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && rstLow && !stbyLow && state_q == sspc_pkg::SSPC_SWSTBY)
      |=> ##1 ctl.clockOn)
    else $error("clocks not restarted on reset");
  settle_wait_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == sspc_pkg::SSPC_SETTLE) |-> !ctl.cpuRun)
    else $error("cpu ran during settle");

  // Exits and holds of each mode, judged one edge after the cause, except standby_stop_a and settle_count_a in the same cycle.
  sleep_wake_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_SLEEP && sleepWake && !rstLow && !stbyLow)
      |=> state_q == sspc_pkg::SSPC_RUN && interruptStart && ctl.cpuRun)
    else $error("sleep not ended by wake");

  sleep_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_SLEEP && rstLow && !stbyLow)
      |=> state_q == sspc_pkg::SSPC_RSTOSC)
    else $error("sleep not ended by reset pin");

  sleep_hwstby_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_SLEEP && stbyLow)
      |=> state_q == sspc_pkg::SSPC_HWSTBY && hwStandby)
    else $error("sleep not ended by standby pin");

  sleep_modules_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_d == sspc_pkg::SSPC_SLEEP) |=> moduleRun == ~$past(moduleStop))
    else $error("module run wrong in sleep");

  standby_stop_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == sspc_pkg::SSPC_SWSTBY) |-> !ctl.clockOn && !ctl.periphRun
      && ctl.periphReset && moduleRun == 7'h00)
    else $error("standby left parts running");

  standby_refuse_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_SWSTBY && !rstLow && !stbyLow && !wake.nmi
      && !(|(wake.irqPend & wake.irqEnable))) |=> state_q == sspc_pkg::SSPC_SWSTBY)
    else $error("standby left on a foreign source");

  settle_load_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && settleLoad) |=> state_q == sspc_pkg::SSPC_SETTLE && ctl.oscRun
      && !ctl.clockOn)
    else $error("settle wait not started");

  settle_exit_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_SETTLE && settleDone && !rstLow && !stbyLow)
      |=> state_q == sspc_pkg::SSPC_RUN && interruptStart && ctl.clockOn)
    else $error("settle wait not ended");

  settle_count_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_SETTLE && settleDone && !rstLow && !stbyLow)
      |-> settleTicks_q == settleExpect - 18'h0_0001)
    else $error("settle wait has wrong length");

  refresh_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && refreshCountClear) |=> !refreshCountClear && refreshStatusClear == 2'h0)
    else $error("refresh clear not a pulse");

  hw_release_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_HWSTBY && !stbyLow)
      |=> state_q == sspc_pkg::SSPC_RSTOSC && !hwStandby)
    else $error("hardware standby not released");

  reset_release_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && state_q == sspc_pkg::SSPC_RSTOSC && !rstLow && !stbyLow)
      |=> state_q == sspc_pkg::SSPC_RUN && resetStart && ctl.cpuRun)
    else $error("reset release not handled");

  sel_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (clockEnable && selWrite) |=> standby_select_bit == $past(selWriteData))
    else $error("select bit write lost");

  //////////////////////////////////////////////////////////////////////////////
  // Check helpers: an independent tally of the settling wait.

  // Code captured at the wake, so a later write cannot skew the tally.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settleCode_q <= `SSPC_STS_RESET;
    end else if (clockEnable) begin
      if (settleLoad) begin
        settleCode_q <= settle_time_select;
      end
    end
  end

  // Divided states seen so far in the settling wait.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settleTicks_q <= 18'h0_0000;
    end else if (clockEnable) begin
      if (state_q != sspc_pkg::SSPC_SETTLE) begin
        settleTicks_q <= 18'h0_0000;
      end else if (divTick) begin
        settleTicks_q <= settleTicks_q + 18'h0_0001;
      end
    end
  end

  // Wait that each code asks for; illegal codes take the longest.
  always_comb begin
    unique case (settleCode_q)
      `SSPC_STS_8K: settleExpect = `SSPC_WAIT_8K;
      `SSPC_STS_16K: settleExpect = `SSPC_WAIT_16K;
      `SSPC_STS_32K: settleExpect = `SSPC_WAIT_32K;
      `SSPC_STS_64K: settleExpect = `SSPC_WAIT_64K;
      `SSPC_STS_128K: settleExpect = `SSPC_WAIT_128K;
      `SSPC_STS_1K: settleExpect = `SSPC_WAIT_1K;
      default: settleExpect = `SSPC_WAIT_128K;
    endcase
  end
endmodule : sspc_power_seq

// file: dv/sspc_host_model.sv
// Behavioural model of the CPU, interrupt controller and standby pins.
`timescale 1ns/1ps
module sspc_host_model #(
  parameter int RST_HOLD = 16
) (
  input wire logic clock,
  output logic sleepExec,
  output logic selWrite,
  output logic selWriteData,
  output logic [2:0] settleWriteData,
  output sspc_pkg::sspc_wake_t wake,
  output logic chip_rst_n_pin,
  output logic hw_standby_n_pin
);
  // Idle levels: no request, both pins released high.
  initial begin
    sleepExec = 1'b0;
    selWrite = 1'b0;
    selWriteData = 1'b0;
    settleWriteData = 3'h0;
    wake = '0;
    chip_rst_n_pin = 1'b1;
    hw_standby_n_pin = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Writes select and settle code for one cycle, then drives the inverted data.
  task automatic program_sel(input logic sel, input logic [2:0] sts);
    @(negedge clock);
    selWrite = 1'b1;
    selWriteData = sel;
    settleWriteData = sts;
    @(negedge clock);
    selWrite = 1'b0;
    selWriteData = ~sel;
    settleWriteData = ~sts;
  endtask : program_sel
  // Executes the sleep instruction for one cycle.
  task automatic do_sleep();
    @(negedge clock);
    sleepExec = 1'b1;
    @(negedge clock);
    sleepExec = 1'b0;
  endtask : do_sleep
  // Raises one set of interrupt requests for a single cycle.
  task automatic pulse_wake(input sspc_pkg::sspc_wake_t w);
    @(negedge clock);
    wake = w;
    @(negedge clock);
    wake = '0;
  endtask : pulse_wake
  // Drives both pins and lets one edge sample them.
  task automatic set_pins(input logic rstN, input logic stbyN);
    @(negedge clock);
    chip_rst_n_pin = rstN;
    hw_standby_n_pin = stbyN;
    @(negedge clock);
  endtask : set_pins
  // Holds reset low long enough for the oscillator to settle.
  task automatic hold_reset();
    @(negedge clock);
    chip_rst_n_pin = 1'b0;
    repeat (RST_HOLD) @(negedge clock);
  endtask : hold_reset
endmodule : sspc_host_model

// file: dv/sspc_power_seq_tb_top.sv
// Self-checking bench for the sleep and standby power sequencer.
`timescale 1ns/1ps
module sspc_power_seq_tb_top;
  logic clock, reset_n, clockEnable, divTick, halfRate;
  logic sleepExec, selWrite, selWriteData, chipRstN, hwStbyN;
  logic [2:0] settleWriteData, settleSel;
  logic [6:0] moduleStop, moduleRun;
  sspc_pkg::sspc_wake_t wake, w;
  sspc_pkg::sspc_ctl_t ctl;
  logic standbySel, refreshCountClear, interruptStart, resetStart, hwStandby;
  logic [1:0] refreshStatusClear;
  logic [5:0] stateOut;
  int bad_count = 0;
  int samples_checked = 0;
  int n;

  sspc_host_model sspc_host_model_inst (.clock(clock), .sleepExec(sleepExec),
    .selWrite(selWrite), .selWriteData(selWriteData), .settleWriteData(settleWriteData),
    .wake(wake), .chip_rst_n_pin(chipRstN), .hw_standby_n_pin(hwStbyN));

  sspc_power_seq sspc_power_seq_inst (.clock(clock), .reset_n(reset_n),
    .clockEnable(clockEnable), .sleepExec(sleepExec), .selWrite(selWrite),
    .selWriteData(selWriteData), .settleWriteData(settleWriteData), .divTick(divTick),
    .moduleStop(moduleStop), .wake(wake), .chip_rst_n_pin(chipRstN),
    .hw_standby_n_pin(hwStbyN), .standby_select_bit(standbySel),
    .settle_time_select(settleSel), .ctl(ctl), .moduleRun(moduleRun),
    .refreshStatusClear(refreshStatusClear), .refreshCountClear(refreshCountClear),
    .interruptStart(interruptStart), .resetStart(resetStart), .hwStandby(hwStandby),
    .stateOut(stateOut));

  // Free-running 40 MHz clock.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Divided-state tick: every cycle, or every other cycle at half rate.
  always @(negedge clock) begin
    divTick <= halfRate ? ~divTick : 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Counts and reports one comparison.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Waits, bounded, for a given state code.
  task automatic wait_state(input logic [5:0] exp, input int limit);
    n = 0;
    while (stateOut !== exp && n < limit) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_state
  // Follows the settling wait to its end and judges its length.
  task automatic settle_exit(input int waitN, input int tol);
    wait_state(6'h01, 2 * waitN + 50);
    check(interruptStart, 1'b1);
    check(n >= waitN - tol && n <= waitN + tol, 1'b1);
    check(standbySel, 1'b1);
  endtask : settle_exit
  // Reset values of the state and controls.
  task automatic test_reset();
    check(stateOut, 6'h01);
    check(ctl, 6'h3c);
    check(moduleRun, 7'h7f);
    check({standbySel, settleSel}, 4'h0);
  endtask : test_reset
  // Sleep entry, refused wakes and the accepted wake.
  task automatic test_sleep();
    moduleStop = 7'h05;
    sspc_host_model_inst.do_sleep();
    check(stateOut, 6'h02);
    check(ctl.cpuRun, 1'b0);
    check(moduleRun, 7'h7a);
    w = '0;
    w.periphReq = 1'b1;
    sspc_host_model_inst.pulse_wake(w);
    check(stateOut, 6'h02);
    w.periphEnabled = 1'b1;
    w.periphCpuMasked = 1'b1;
    sspc_host_model_inst.pulse_wake(w);
    check(stateOut, 6'h02);
    clockEnable = 1'b0;
    w.periphCpuMasked = 1'b0;
    sspc_host_model_inst.pulse_wake(w);
    check(stateOut, 6'h02);
    clockEnable = 1'b1;
    sspc_host_model_inst.pulse_wake(w);
    check({stateOut, interruptStart, ctl.cpuRun}, 8'h07);
  endtask : test_sleep
  // Pin exits from sleep.
  task automatic test_sleep_pins();
    sspc_host_model_inst.do_sleep();
    sspc_host_model_inst.hold_reset();
    check(stateOut, 6'h10);
    sspc_host_model_inst.set_pins(1'b1, 1'b1);
    check({stateOut, resetStart}, 7'h03);
    sspc_host_model_inst.do_sleep();
    sspc_host_model_inst.set_pins(1'b1, 1'b0);
    check({stateOut, hwStandby}, 7'h41);
    sspc_host_model_inst.set_pins(1'b0, 1'b0);
    sspc_host_model_inst.set_pins(1'b0, 1'b1);
    sspc_host_model_inst.set_pins(1'b1, 1'b1);
    check(stateOut, 6'h01);
  endtask : test_sleep_pins
  // Standby entry, refused wakes, then each waking source in turn.
  task automatic test_standby();
    sspc_host_model_inst.program_sel(1'b1, 3'h5);
    check({standbySel, settleSel}, 4'hd);
    for (int src = 0; src < 4; src++) begin
      sspc_host_model_inst.do_sleep();
      check(stateOut, 6'h04);
      check(ctl[5:2], 4'h0);
      check(ctl[1:0], 2'h3);
      check({refreshStatusClear, refreshCountClear}, 3'h7);
      w = '0;
      w.periphReq = 1'b1;
      w.periphEnabled = 1'b1;
      sspc_host_model_inst.pulse_wake(w);
      check(stateOut, 6'h04);
      w = '0;
      w.irqPend = 3'h7;
      sspc_host_model_inst.pulse_wake(w);
      check(stateOut, 6'h04);
      w.irqEnable = 3'h7;
      w.irqCpuMasked = 1'b1;
      sspc_host_model_inst.pulse_wake(w);
      check(stateOut, 6'h04);
      w = '0;
      if (src == 3) begin
        w.nmi = 1'b1;
      end else begin
        w.irqPend[src] = 1'b1;
        w.irqEnable[src] = 1'b1;
      end
      sspc_host_model_inst.pulse_wake(w);
      check({stateOut, ctl.oscRun, ctl.clockOn}, 8'h22);
      settle_exit(1024, 3);
    end
  endtask : test_standby
  // Long settle codes, and the short code counted at half tick rate.
  task automatic test_settle();
    logic [2:0] codes [3] = '{3'h0, 3'h1, 3'h5};
    int waits [3] = '{8192, 16384, 2048};
    for (int i = 0; i < 3; i++) begin
      halfRate = (i == 2);
      sspc_host_model_inst.program_sel(1'b1, codes[i]);
      sspc_host_model_inst.do_sleep();
      w = '0;
      w.nmi = 1'b1;
      sspc_host_model_inst.pulse_wake(w);
      settle_exit(waits[i], 4);
    end
    halfRate = 1'b0;
  endtask : test_settle
  // Long and illegal codes still settle past the short wait; reset pin cuts it.
  task automatic test_settle_abort();
    for (int c = 2; c < 8; c++) begin
      if (c != 5) begin
        sspc_host_model_inst.program_sel(1'b1, 3'(c));
        sspc_host_model_inst.do_sleep();
        w = '0;
        w.nmi = 1'b1;
        sspc_host_model_inst.pulse_wake(w);
        repeat (1100) @(negedge clock);
        check(stateOut, 6'h08);
        sspc_host_model_inst.hold_reset();
        check({stateOut, ctl.clockOn}, 7'h21);
        sspc_host_model_inst.set_pins(1'b1, 1'b1);
        check({stateOut, resetStart}, 7'h03);
      end
    end
  endtask : test_settle_abort
  // Pin exits from software standby.
  task automatic test_standby_pins();
    sspc_host_model_inst.do_sleep();
    sspc_host_model_inst.hold_reset();
    check({stateOut, ctl.clockOn}, 7'h21);
    sspc_host_model_inst.set_pins(1'b1, 1'b1);
    check({stateOut, resetStart}, 7'h03);
    sspc_host_model_inst.do_sleep();
    sspc_host_model_inst.set_pins(1'b1, 1'b0);
    check({stateOut, hwStandby}, 7'h41);
    sspc_host_model_inst.set_pins(1'b0, 1'b0);
    sspc_host_model_inst.set_pins(1'b0, 1'b1);
    sspc_host_model_inst.set_pins(1'b1, 1'b1);
    check(stateOut, 6'h01);
  endtask : test_standby_pins
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence after five cycles of reset.
  initial begin
    reset_n = 1'b0;
    clockEnable = 1'b1;
    divTick = 1'b1;
    halfRate = 1'b0;
    moduleStop = 7'h00;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    test_reset();
    test_sleep();
    test_sleep_pins();
    test_standby();
    test_settle();
    test_settle_abort();
    test_standby_pins();
    give_verdict();
  end
  // Cuts a hang short well beyond the expected run of about 37000 cycles.
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
endmodule : sspc_power_seq_tb_top
